/* src/tps_port_regs.sv */
// Port power, line status and fault register logic with link side register access
`timescale 1ns/10ps
module tps_port_regs #(
  parameter int MEAS_W = 10  // Width of the voltage reading
) (
  // Clocks and resets
  input  wire logic                i_mclk,
  input  wire logic                i_rst_b,
  input  wire logic                i_lclk,
  input  wire logic                i_lrst_b,
  // Register access on the link clock
  input  wire logic [7:0]          i_reg_addr,
  input  wire logic [7:0]          i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic      [7:0]          o_reg_rdata,
  output logic                     o_reg_done,
  output logic                     o_reg_busy,
  // Analog comparators and pins
  input  wire logic                i_sup_above_hi,
  input  wire logic                i_sup_below_lo,
  input  wire logic                i_sup_safe0,
  input  wire logic                i_sup_below_stop,
  input  wire logic                i_cp_cc1_seen,
  input  wire logic                i_cp_cc2_seen,
  input  wire logic                i_dbg_accessory_output,
  input  wire logic                i_disconnect,
  input  wire logic [1:0]          i_cc1_detect,
  input  wire logic [1:0]          i_cc2_detect,
  input  wire logic                i_alarm_hi,
  input  wire logic                i_alarm_lo,
  // Same clock logic
  input  wire logic                i_attach_search_flag,
  input  wire logic                i_attach_role,
  input  wire logic                i_startup_pending,
  input  wire logic                i_supply_detect_active,
  input  wire logic [1:0]          i_cc1_cfg,
  input  wire logic [1:0]          i_cc2_cfg,
  input  wire logic                i_orientation,
  input  wire logic                i_source_role,
  input  wire logic                i_source_req,
  input  wire logic [MEAS_W-1:0]   i_supply_measure,
  input  wire logic [7:0]          i_fault_set,
  input  wire logic [7:0]          i_fault_mask,
  input  wire logic                i_alert_fault_mask,
  // Power path and status outputs
  output logic                     o_source_on,
  output logic                     o_drain_on,
  output logic                     o_bleed_on,
  output logic                     o_cable_power_cc1,
  output logic                     o_cable_power_cc2,
  output logic                     o_monitor_cc2,
  output logic [MEAS_W-1:0]        o_supply_measure,
  output logic                     o_alarm_hi_report,
  output logic                     o_alarm_lo_report,
  output logic                     o_alert_fault_set,
  output logic                     o_irq_b
);
  import tps_pkg::*;

  // Refuse widths the reading port cannot serve
  if (MEAS_W < 1 || MEAS_W > 16) begin : g_chk
    $error("MEAS_W out of range");
  end

  // Main domain state
  typedef struct packed {
    logic [TPS_PIN_W-1:0] s1;    // Pin sync first stage
    logic [TPS_PIN_W-1:0] s2;    // Pin sync second stage
    logic                 disc;  // Last disconnect level
    logic                 rq1;   // Request toggle sync
    logic                 rq2;
    logic                 rq3;   // Edge reference
    logic                 ack;   // Answer toggle
    logic [7:0]           rd;    // Read data held for link
    logic [7:0]           ctrl;  // Discharge, cable power and monitoring control
    logic [7:0]           cc;    // Line status
    logic [7:0]           pwr;   // Power condition status
    logic [7:0]           flt;   // Fault latch status
    tps_drain_t           st;    // Discharge sequencer
    logic                 src;
    logic                 drn;
    logic                 bld;
    logic                 cp1;
    logic                 cp2;
    logic                 mon2;
    logic [MEAS_W-1:0]    meas;
    logic                 ahi;
    logic                 alo;
    logic                 alert;
    logic                 irq_b;
  } tps_main_t;

  // Link domain state
  typedef struct packed {
    logic       req;   // Request toggle
    logic       as1;   // Answer toggle sync
    logic       as2;
    logic       as3;
    logic       busy;  // Transfer outstanding
    logic       done;  // Answer pulse
    logic [7:0] rdat;
    logic [7:0] hadr;  // Held address, stable while busy
    logic [7:0] hdat;  // Held write data
    logic       hwr;   // Held write flag
  } tps_link_t;

  tps_main_t s;
  tps_main_t n;
  tps_link_t l;
  tps_link_t m;

  logic [TPS_PIN_W-1:0] pins;  // Raw pin vector
  logic                 go;    // Request seen in main domain
  logic                 we;    // Write applied this cycle
  logic                 dn;    // Discharge target reached
  logic                 dedge; // Disconnect detected
  logic [7:0]           w1c;   // Fault bits written with one
  logic                 blk1;  // Line one field forced to zero
  logic                 blk2;

  // Line state field, zero when not meaningful
  function automatic logic [1:0] cc_field(input logic [1:0] cfg, input logic [1:0] det,
                                          input logic blk);
    cc_field = (blk || cfg == TPS_CFG_RA || cfg == TPS_CFG_OPEN) ? 2'h0 : det;
  endfunction

  // Read decode, unmapped offsets read zero
  function automatic logic [7:0] reg_read(input logic [7:0] adr, input tps_main_t r);
    case (adr)
      TPS_OFF_CTRL: reg_read = r.ctrl;
      TPS_OFF_CC:   reg_read = r.cc;
      TPS_OFF_PWR:  reg_read = r.pwr;
      TPS_OFF_FLT:  reg_read = r.flt;
      default:      reg_read = 8'h00;
    endcase
  endfunction
  assign pins = {i_alarm_lo, i_alarm_hi, i_cc2_detect, i_cc1_detect, i_disconnect,
                 i_dbg_accessory_output, i_cp_cc2_seen, i_cp_cc1_seen, i_sup_below_stop,
                 i_sup_safe0, i_sup_below_lo, i_sup_above_hi};
  // Helper terms from synchronised levels, held link fields and same clock inputs
  always_comb begin
    go    = s.rq2 ^ s.rq3;
    we    = go & l.hwr;
    dn    = s.s2[TPS_P_SAFE0] | s.s2[TPS_P_STOP];
    dedge = s.s2[TPS_P_DISC] & ~s.disc;
    w1c   = (we && l.hadr == TPS_OFF_FLT) ? l.hdat : 8'h00;
    blk1  = i_attach_search_flag | (s.ctrl[TPS_B_VCONN] & i_orientation);
    blk2  = i_attach_search_flag | (s.ctrl[TPS_B_VCONN] & ~i_orientation);
  end
  // Main domain next state
  always_comb begin
    n      = s;
    n.s1   = pins;
    n.s2   = s.s1;
    n.disc = s.s2[TPS_P_DISC];
    n.rq1  = l.req;
    n.rq2  = s.rq1;
    n.rq3  = s.rq2;
    // Answer a request; hold data is stable while the link waits
    if (go) begin
      n.ack = ~s.ack;
      n.rd  = reg_read(l.hadr, s);
    end
    // Discharge sequencer
    case (s.st)
      TPS_IDLE: begin
        if (s.ctrl[TPS_B_AUTO_DIS] && dedge) begin
          n.st  = TPS_AUTO;
          n.drn = 1'b1;
        end else if (s.ctrl[TPS_B_FORCE]) begin
          n.st  = TPS_FORCE;
          n.drn = 1'b1;
        end
      end
      TPS_AUTO: begin
        if (dn) begin
          n.st  = TPS_IDLE;
          n.drn = 1'b0;
        end
      end
      TPS_FORCE: begin
        // self clear on target; a software clear aborts the same way
        if (dn || !s.ctrl[TPS_B_FORCE]) begin
          n.st                = TPS_IDLE;
          n.drn               = 1'b0;
          n.ctrl[TPS_B_FORCE] = 1'b0;
        end
      end
      default: begin
        n.st  = TPS_IDLE;
        n.drn = 1'b0;
      end
    endcase
    // sourcing drops no later than discharge
    n.src = (n.st == TPS_IDLE) & i_source_role & i_source_req;
    // Software write after self clear, so a fresh set is kept
    if (we && l.hadr == TPS_OFF_CTRL) begin
      n.ctrl = l.hdat & TPS_CTRL_WMASK;
    end
    n.bld  = s.ctrl[TPS_B_BLEED];
    n.cp1  = s.ctrl[TPS_B_VCONN] & i_orientation;
    n.cp2  = s.ctrl[TPS_B_VCONN] & ~i_orientation;
    n.mon2 = i_orientation;
    n.meas = s.ctrl[TPS_B_MEAS_DIS] ? '0 : i_supply_measure;
    n.ahi  = s.s2[TPS_P_AHI] & ~s.ctrl[TPS_B_ALARM_DIS];
    n.alo  = s.s2[TPS_P_ALO] & ~s.ctrl[TPS_B_ALARM_DIS];
    n.cc = 8'h00;
    n.cc[TPS_B_SEARCH] = i_attach_search_flag;
    n.cc[TPS_B_ROLE]   = i_attach_role;
    n.cc[1:0] = cc_field(i_cc1_cfg, s.s2[TPS_P_CC1 +: 2], blk1);
    n.cc[3:2] = cc_field(i_cc2_cfg, s.s2[TPS_P_CC2 +: 2], blk2);
    n.pwr = 8'h00;
    n.pwr[TPS_B_DBG]     = s.s2[TPS_P_DBG];
    n.pwr[TPS_B_STARTUP] = i_startup_pending;
    n.pwr[TPS_B_DET_ACT] = i_supply_detect_active;
    n.pwr[TPS_B_SUP] = s.s2[TPS_P_HI] | (~s.s2[TPS_P_LO] & s.pwr[TPS_B_SUP]);
    n.pwr[TPS_B_CP_SEEN] = s.ctrl[TPS_B_VCONN] & (s.s2[TPS_P_VC1] | s.s2[TPS_P_VC2]);
    // latch faults, a new event beats a clear
    n.flt   = (s.flt & ~w1c) | (i_fault_set & TPS_FLT_SUP);
    n.alert = |(i_fault_set & TPS_FLT_SUP);
    // active low interrupt, masks of one pass
    n.irq_b = ~(i_alert_fault_mask & (|(n.flt & i_fault_mask)));
  end
  // Main domain registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s       <= '0;
      s.ctrl  <= TPS_CTRL_RST;
      s.cc    <= TPS_CC_RST;
      s.pwr   <= TPS_PWR_RST;
      s.flt   <= TPS_FLT_RST;
      s.st    <= TPS_IDLE;
      s.irq_b <= 1'b1;
    end else begin
      s <= n;
    end
  end
  // Link domain next state
  always_comb begin
    m      = l;
    m.as1  = s.ack;
    m.as2  = l.as1;
    m.as3  = l.as2;
    m.done = 1'b0;
    // Answer arrives; main read data is stable until next request
    if (l.as2 ^ l.as3) begin
      m.busy = 1'b0;
      m.done = 1'b1;
      m.rdat = s.rd;
    end else if (!l.busy && (i_reg_wr || i_reg_rd)) begin
      m.busy = 1'b1;
      m.req  = ~l.req;
      m.hadr = i_reg_addr;
      m.hdat = i_reg_wdata;
      m.hwr  = i_reg_wr;
    end
  end
  // Link domain registers
  always_ff @(posedge i_lclk) begin
    if (!i_lrst_b) begin
      l <= '0;
    end else begin
      l <= m;
    end
  end
  // Outputs straight from flip-flops
  assign o_reg_rdata       = l.rdat;
  assign o_reg_done        = l.done;
  assign o_reg_busy        = l.busy;
  assign o_source_on       = s.src;
  assign o_drain_on        = s.drn;
  assign o_bleed_on        = s.bld;
  assign o_cable_power_cc1 = s.cp1;
  assign o_cable_power_cc2 = s.cp2;
  assign o_monitor_cc2     = s.mon2;
  assign o_supply_measure  = s.meas;
  assign o_alarm_hi_report = s.ahi;
  assign o_alarm_lo_report = s.alo;
  assign o_alert_fault_set = s.alert;
  assign o_irq_b           = s.irq_b;
  chk_meas_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.ctrl[TPS_B_MEAS_DIS] |=> s.meas == '0)
    else $error("reading not zero while disabled");
  chk_alarm_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.ctrl[TPS_B_ALARM_DIS] |=> !s.ahi && !s.alo)
    else $error("alarm reported while disabled");
  chk_src_drain: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.drn |-> !s.src)
    else $error("sourcing while discharging");
  // no auto discharge with bit clear
  chk_auto_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.st == TPS_IDLE && !s.ctrl[TPS_B_AUTO_DIS] |=> s.st != TPS_AUTO)
    else $error("auto discharge with bit clear");
  chk_drain_end: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.st != TPS_IDLE && dn |=> s.st == TPS_IDLE ##1 !s.drn)
    else $error("discharge kept past target");
  chk_force_clr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.st == TPS_FORCE && dn && !we |=> !s.ctrl[TPS_B_FORCE])
    else $error("force bit not cleared");
  chk_bleed_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !s.ctrl[TPS_B_BLEED] ##1 !s.ctrl[TPS_B_BLEED] |-> !s.bld)
    else $error("bleed load while disabled");
  chk_cp_route: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s.cp1 || s.cp2) |-> $past(s.ctrl[TPS_B_VCONN]) && !(s.cp1 && s.cp2))
    else $error("cable power misrouted");
  chk_cc_search: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s.cc[TPS_B_SEARCH] |-> s.cc[3:0] == 4'h0)
    else $error("line field set while searching");
  chk_cp_seen: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !s.ctrl[TPS_B_VCONN] |=> !s.pwr[TPS_B_CP_SEEN])
    else $error("cable power seen while disabled");
  // zero writes do not clear faults
  chk_flt_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    w1c == 8'h00 |=> (s.flt & $past(s.flt)) == $past(s.flt))
    else $error("fault bit lost without clear");
  // interrupt released when alert mask is zero
  chk_irq_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_alert_fault_mask |=> s.irq_b)
    else $error("interrupt asserted while masked");
endmodule

/* src/tps_pkg.sv */
// Package with offsets, reset values, field layouts and states of the port status registers
package tps_pkg;
  // Register offsets
  localparam logic [7:0] TPS_OFF_CTRL = 8'h1C;
  localparam logic [7:0] TPS_OFF_CC   = 8'h1D;
  localparam logic [7:0] TPS_OFF_PWR  = 8'h1E;
  localparam logic [7:0] TPS_OFF_FLT  = 8'h1F;
  // Values after reset
  localparam logic [7:0] TPS_CTRL_RST = 8'h60;
  localparam logic [7:0] TPS_CC_RST   = 8'h10;
  localparam logic [7:0] TPS_PWR_RST  = 8'h00;
  localparam logic [7:0] TPS_FLT_RST  = 8'h80;
  // Writable control bits, supported fault bits
  localparam logic [7:0] TPS_CTRL_WMASK = 8'h7D;
  localparam logic [7:0] TPS_FLT_SUP    = 8'hB3;
  // Control field positions
  localparam int TPS_B_MEAS_DIS  = 6;
  localparam int TPS_B_ALARM_DIS = 5;
  localparam int TPS_B_AUTO_DIS  = 4;
  localparam int TPS_B_BLEED     = 3;
  localparam int TPS_B_FORCE     = 2;
  localparam int TPS_B_VCONN     = 0;
  // Status field positions
  localparam int TPS_B_SEARCH   = 5;
  localparam int TPS_B_ROLE     = 4;
  localparam int TPS_B_DBG      = 7;
  localparam int TPS_B_STARTUP  = 6;
  localparam int TPS_B_DET_ACT  = 3;
  localparam int TPS_B_SUP      = 2;
  localparam int TPS_B_CP_SEEN  = 1;
  // Line configuration codes
  localparam logic [1:0] TPS_CFG_RA   = 2'h0;
  localparam logic [1:0] TPS_CFG_OPEN = 2'h3;
  // Positions in the synchronised pin vector
  localparam int TPS_P_HI    = 0;
  localparam int TPS_P_LO    = 1;
  localparam int TPS_P_SAFE0 = 2;
  localparam int TPS_P_STOP  = 3;
  localparam int TPS_P_VC1   = 4;
  localparam int TPS_P_VC2   = 5;
  localparam int TPS_P_DBG   = 6;
  localparam int TPS_P_DISC  = 7;
  localparam int TPS_P_CC1   = 8;
  localparam int TPS_P_CC2   = 10;
  localparam int TPS_P_AHI   = 12;
  localparam int TPS_P_ALO   = 13;
  localparam int TPS_PIN_W   = 14;
  // Discharge sequencer states
  typedef enum logic [1:0] {TPS_IDLE, TPS_AUTO, TPS_FORCE} tps_drain_t;
endpackage

/* testbench/tps_pm_model.sv */
// Port manager model issuing single byte register accesses on the link clock
`timescale 1ns/10ps
module tps_pm_model (
  // Link clock
  input  wire logic       i_lclk,
  // Requests towards the block
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  // Answers from the block
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_done
);
  logic stuck;  // Sticky, an access never got its answer

  // Idle bus at time zero
  initial begin
    {o_addr, o_wdata, o_wr, o_rd, stuck} = '0;
  end

  // One access, one outstanding; the caller waits for the answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    q = 8'h00;
    @(posedge i_lclk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= w;
    o_rd    <= !w;
    @(posedge i_lclk);
    // Released address and data show the inverse and both strobes drop, so a stale value cannot pass
    o_addr  <= ~a;
    o_wdata <= ~d;
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    // Answer taken at the edge where done is sampled high
    while (n < 40) begin
      @(posedge i_lclk);
      n++;
      if (i_done === 1'b1) begin
        q = i_rdata;
        break;
      end
    end
    if (n >= 40) begin
      stuck = 1'b1;
    end
  endtask
endmodule

/* testbench/test_typec_port_power_status_regs.sv */
// Self-checking bench for the port power, line status and fault registers
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module test_typec_port_power_status_regs;
  import tps_pkg::*;
  // Clocks, resets and register access
  logic i_mclk, i_rst_b, i_lclk, i_lrst_b, i_reg_wr, i_reg_rd, o_reg_done, o_reg_busy;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_fault_set, i_fault_mask;
  // Comparator and pin levels
  logic i_sup_above_hi, i_sup_below_lo, i_sup_safe0, i_sup_below_stop, i_cp_cc1_seen;
  logic i_cp_cc2_seen, i_dbg_accessory_output, i_disconnect, i_alarm_hi, i_alarm_lo;
  logic [1:0] i_cc1_detect, i_cc2_detect, i_cc1_cfg, i_cc2_cfg;
  // Same clock levels
  logic i_attach_search_flag, i_attach_role, i_startup_pending, i_supply_detect_active;
  logic i_orientation, i_source_role, i_source_req, i_alert_fault_mask;
  logic [9:0] i_supply_measure, o_supply_measure;
  // Power path and status outputs
  logic o_source_on, o_drain_on, o_bleed_on, o_cable_power_cc1, o_cable_power_cc2;
  logic o_monitor_cc2, o_alarm_hi_report, o_alarm_lo_report, o_alert_fault_set, o_irq_b;
  int   mismatches = 0;  // Failed comparisons
  int   checked    = 0;  // All comparisons
  logic alert_seen = 0;  // Alert pulse caught since last clear

  tps_port_regs #(.MEAS_W(10)) DUT (.i_mclk, .i_rst_b, .i_lclk, .i_lrst_b, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_done, .o_reg_busy,
    .i_sup_above_hi, .i_sup_below_lo, .i_sup_safe0, .i_sup_below_stop, .i_cp_cc1_seen,
    .i_cp_cc2_seen, .i_dbg_accessory_output, .i_disconnect, .i_cc1_detect, .i_cc2_detect,
    .i_alarm_hi, .i_alarm_lo, .i_attach_search_flag, .i_attach_role, .i_startup_pending,
    .i_supply_detect_active, .i_cc1_cfg, .i_cc2_cfg, .i_orientation, .i_source_role,
    .i_source_req, .i_supply_measure, .i_fault_set, .i_fault_mask, .i_alert_fault_mask,
    .o_source_on, .o_drain_on, .o_bleed_on, .o_cable_power_cc1, .o_cable_power_cc2,
    .o_monitor_cc2, .o_supply_measure, .o_alarm_hi_report, .o_alarm_lo_report,
    .o_alert_fault_set, .o_irq_b);
  tps_pm_model PM (.i_lclk(i_lclk), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata),
    .o_wr(i_reg_wr), .o_rd(i_reg_rd), .i_rdata(o_reg_rdata), .i_done(o_reg_done));

  // Main clock, 200 MHz
  always #2.5 i_mclk = ~i_mclk;
  // Link clock, 12 ns, offset so the edges drift against the main clock
  initial begin
    i_lclk = 1'b0;
    #1.3;
    forever #6 i_lclk = ~i_lclk;
  end
  // Alert is a one cycle pulse, so it is caught here
  always @(posedge i_mclk) if (o_alert_fault_set === 1'b1) alert_seen <= 1'b1;

  task automatic mwait(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    PM.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    PM.xfer(1'b0, a, 8'h00, q);
    `CHK(n, e, q)
  endtask
  // One cycle fault set pulse on the main clock
  task automatic pulse(input logic [7:0] v);
    alert_seen = 1'b0;
    @(posedge i_mclk) i_fault_set <= v;
    @(posedge i_mclk) i_fault_set <= 8'h00;
    mwait(3);
  endtask

  task automatic t_reset();
    logic [7:0] adr [5];
    logic [7:0] exp [5];
    adr = '{TPS_OFF_CTRL, TPS_OFF_CC, TPS_OFF_PWR, TPS_OFF_FLT, 8'h40};
    exp = '{TPS_CTRL_RST, TPS_CC_RST, TPS_PWR_RST, TPS_FLT_RST, 8'h00};
    // Busy stands from the cycle after the request until the answer
    fork
      wr(8'h40, 8'hFF);
      begin
        repeat (3) @(posedge i_lclk);
        `CHK("busy high", 1'b1, o_reg_busy)
      end
    join
    `CHK("busy low", 1'b0, o_reg_busy)
    wr(TPS_OFF_CC, 8'hEF);
    for (int k = 0; k < 5; k++) rd_chk("reset value", adr[k], exp[k]);
    `CHK("irq idle", 1'b1, o_irq_b)
  endtask

  task automatic t_ctrl();
    @(posedge i_mclk) {i_alarm_hi, i_alarm_lo} <= 2'b11;
    mwait(6);
    `CHK("measure off", 10'h000, o_supply_measure)
    `CHK("alarm off", 2'b00, {o_alarm_hi_report, o_alarm_lo_report})
    wr(TPS_OFF_CTRL, 8'hFF);
    rd_chk("ctrl mask", TPS_OFF_CTRL, 8'h7D);
    `CHK("bleed on", 1'b1, o_bleed_on)
    wr(TPS_OFF_CTRL, 8'h00);
    mwait(4);
    `CHK("bleed off", 1'b0, o_bleed_on)
    `CHK("measure on", 10'h2A5, o_supply_measure)
    `CHK("alarm on", 2'b11, {o_alarm_hi_report, o_alarm_lo_report})
    wr(TPS_OFF_CTRL, 8'h60);
  endtask

  task automatic t_vconn();
    @(posedge i_mclk) {i_cc1_cfg, i_cc2_cfg, i_cc1_detect, i_cc2_detect} <= 8'hAD;
    {i_cp_cc1_seen, i_cp_cc2_seen} <= 2'b11;
    for (int o = 0; o < 2; o++) begin
      @(posedge i_mclk) i_orientation <= o[0];
      wr(TPS_OFF_CTRL, 8'h01);
      mwait(6);
      `CHK("power cc1", o[0], o_cable_power_cc1)
      `CHK("power cc2", !o[0], o_cable_power_cc2)
      `CHK("monitor", o[0], o_monitor_cc2)
      rd_chk("cc powered", TPS_OFF_CC, o[0] ? 8'h14 : 8'h13);
      rd_chk("vconn seen", TPS_OFF_PWR, 8'h02);
      wr(TPS_OFF_CTRL, 8'h00);
      rd_chk("vconn off", TPS_OFF_PWR, 8'h00);
    end
  endtask

  task automatic t_cc();
    logic [1:0] a;
    logic [1:0] b;
    for (int k = 0; k < 7; k++) begin
      a = (k < 4) ? k[1:0] : 2'(k - 4);
      b = (k < 4) ? 2'(3 - k) : 2'(6 - k);
      @(posedge i_mclk) {i_cc1_detect, i_cc2_detect} <= {a, b};
      {i_cc1_cfg, i_cc2_cfg, i_attach_role} <= (k < 4) ? 5'b10101 : 5'b01010;
      mwait(6);
      rd_chk("cc code", TPS_OFF_CC, {3'b000, k < 4, b, a});
    end
    @(posedge i_mclk) {i_cc1_cfg, i_cc2_cfg, i_attach_role} <= {TPS_CFG_RA, TPS_CFG_OPEN, 1'b1};
    mwait(6);
    rd_chk("cc ra open", TPS_OFF_CC, 8'h10);
    @(posedge i_mclk) {i_cc1_cfg, i_cc2_cfg, i_attach_search_flag} <= 5'b10101;
    mwait(6);
    rd_chk("cc search", TPS_OFF_CC, 8'h30);
    @(posedge i_mclk) i_attach_search_flag <= 1'b0;
  endtask

  task automatic t_pwr();
    @(posedge i_mclk) {i_dbg_accessory_output, i_startup_pending} <= 2'b11;
    {i_supply_detect_active, i_sup_above_hi, i_sup_below_lo} <= 3'b110;
    mwait(6);
    rd_chk("pwr all", TPS_OFF_PWR, 8'hCC);
    @(posedge i_mclk) {i_dbg_accessory_output, i_startup_pending} <= 2'b00;
    {i_sup_above_hi, i_sup_below_lo} <= 2'b01;
    mwait(6);
    rd_chk("pwr low", TPS_OFF_PWR, 8'h08);
    @(posedge i_mclk) i_supply_detect_active <= 1'b0;
  endtask

  task automatic t_fault();
    // Clearing by writing one, then the alert bit outside this block
    wr(TPS_OFF_FLT, 8'h80);
    rd_chk("flt clear", TPS_OFF_FLT, 8'h00);
    @(posedge i_mclk) {i_fault_mask, i_alert_fault_mask} <= 9'h1FF;
    pulse(8'h20);
    `CHK("alert", 1'b1, alert_seen)
    `CHK("irq low", 1'b0, o_irq_b)
    wr(TPS_OFF_FLT, 8'h00);
    rd_chk("flt zero wr", TPS_OFF_FLT, 8'h20);
    wr(TPS_OFF_FLT, 8'h20);
    rd_chk("flt w1c", TPS_OFF_FLT, 8'h00);
    `CHK("irq back", 1'b1, o_irq_b)
    pulse(8'h4C);
    rd_chk("flt unsup", TPS_OFF_FLT, 8'h00);
    `CHK("no alert", 1'b0, alert_seen)
    @(posedge i_mclk) i_fault_mask <= 8'hFE;
    pulse(8'h01);
    `CHK("irq masked", 1'b1, o_irq_b)
    rd_chk("flt masked", TPS_OFF_FLT, 8'h01);
    wr(TPS_OFF_FLT, 8'h01);
  endtask

  // Disconnect edge with the given role and control value; expect discharge or not
  task automatic disc(input logic src, input logic [7:0] c, input logic e);
    @(posedge i_mclk) {i_source_role, i_source_req, i_disconnect} <= {src, src, 1'b0};
    {i_sup_safe0, i_sup_below_stop} <= 2'b00;
    wr(TPS_OFF_CTRL, c);
    mwait(6);
    `CHK("sourcing", src, o_source_on)
    @(posedge i_mclk) i_disconnect <= 1'b1;
    for (int n = 0; n < 10; n++) begin
      @(posedge i_mclk);
      if (o_drain_on === 1'b1) `CHK("source off", 1'b0, o_source_on)
    end
    `CHK("drain start", e, o_drain_on)
    @(posedge i_mclk) {i_sup_safe0, i_sup_below_stop} <= src ? 2'b10 : 2'b01;
    mwait(8);
    `CHK("drain end", 1'b0, o_drain_on)
  endtask

  task automatic t_force();
    @(posedge i_mclk) {i_sup_safe0, i_sup_below_stop, i_disconnect} <= 3'b000;
    wr(TPS_OFF_CTRL, 8'h64);
    mwait(2);
    `CHK("force drain", 1'b1, o_drain_on)
    @(posedge i_mclk) i_sup_below_stop <= 1'b1;
    mwait(8);
    `CHK("force end", 1'b0, o_drain_on)
    rd_chk("force clr", TPS_OFF_CTRL, 8'h60);
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few microseconds
  initial begin
    #400us;
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial begin
    i_mclk = 1'b0;
    {i_rst_b, i_lrst_b, i_fault_set, i_fault_mask, i_alert_fault_mask} = '0;
    {i_sup_above_hi, i_sup_below_lo, i_sup_safe0, i_sup_below_stop, i_cp_cc1_seen} = '0;
    {i_cp_cc2_seen, i_dbg_accessory_output, i_disconnect, i_alarm_hi, i_alarm_lo} = '0;
    {i_cc1_detect, i_cc2_detect, i_cc1_cfg, i_cc2_cfg, i_attach_search_flag} = '0;
    {i_startup_pending, i_supply_detect_active, i_orientation, i_source_role} = '0;
    i_source_req = 1'b0;
    i_attach_role = 1'b1;
    i_supply_measure = 10'h2A5;
    mwait(20);
    i_rst_b <= 1'b1;
    @(posedge i_lclk) i_lrst_b <= 1'b1;
    mwait(4);
    t_reset();
    t_ctrl();
    t_vconn();
    t_cc();
    t_pwr();
    t_fault();
    disc(1'b1, 8'h70, 1'b1);
    disc(1'b0, 8'h70, 1'b1);
    disc(1'b0, 8'h60, 1'b0);
    t_force();
    `CHK("answers", 1'b0, PM.stuck)
    end_sim();
  end
endmodule
